// file: include/uiw_pkg.sv
// Package for the serial-port interrupt and wake block.
// Assumes a single 250 MHz system clock and an APB master.
package uiw_pkg;
    // Register byte offsets
    localparam logic [7:0] UIW_CTRL_OFS = 8'h00;
    localparam logic [7:0] UIW_STAT_OFS = 8'h04;
    localparam logic [7:0] UIW_IRQEN_OFS = 8'h08;
    localparam logic [7:0] UIW_SETTLE_OFS = 8'h0C;
    // Control register fields (port_control_two image)
    localparam int UIW_TEIE_BIT = 0;
    localparam int UIW_TIIE_BIT = 1;
    localparam int UIW_RIE_BIT = 2;
    localparam int UIW_ADDEN_BIT = 3;
    localparam int UIW_WAKE_BIT = 4;
    localparam int UIW_NINE_BIT = 5;
    localparam int UIW_PAREN_BIT = 6;
    localparam int UIW_PORTEN_BIT = 7;
    localparam int UIW_RXEN_BIT = 8;
    localparam int UIW_CTRL_W = 9;
    // Interrupt enable register fields
    localparam int UIW_GIE_BIT = 0;
    localparam int UIW_MFIE_BIT = 1;
    localparam int UIW_PIE_BIT = 2;
    localparam logic [UIW_CTRL_W-1:0] UIW_CTRL_RST = 9'h000;
    localparam logic [2:0] UIW_IRQEN_RST = 3'h0;
    // Post-wake settling time
    localparam int UIW_SETTLE_NS = 1024;
    localparam int UIW_CLK_MHZ = 250;
    localparam int UIW_SETTLE_CYC = (UIW_SETTLE_NS * UIW_CLK_MHZ + 999) / 1000;
    localparam logic [15:0] UIW_SETTLE_RST = 16'(UIW_SETTLE_CYC);

    typedef enum logic [1:0] {
        UIW_RUN = 2'b00,
        UIW_DOWN = 2'b01,
        UIW_SETTLE = 2'b11
    } uiw_pwr_e;

    // Events from the transmitter and receiver
    typedef struct packed {
        logic tx_empty;
        logic tx_idle;
        logic rx_avail;
        logic overrun;
        logic [8:0] rx_word;
    } uiw_evt_s;
endpackage

// file: design/uiw_irq_wake.sv
// Serial-port interrupt merge, address qualification and power-down wake.
// Assumes shift/framing logic outside supplies status flags and word strobes.
//
// Local design decisions: the APB slave port and the placing of the registers.
module uiw_irq_wake
    import uiw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Port events and power state
    input wire uiw_evt_s evt,
    input wire logic power_down,
    input wire logic stack_full,
    input wire logic serial_data_pin,
    // Port controls out
    output logic port_clk_run,
    output logic rx_ignore,
    output logic [UIW_CTRL_W-1:0] port_control_two,
    // Requests
    output logic port_irq_n,
    output logic vector_take,
    output logic wake_req
);
    logic [UIW_CTRL_W-1:0] ctrl_reg;
    logic [2:0] irqen_reg;
    logic [15:0] settle_reg;
    uiw_pwr_e pwr_reg;
    logic [15:0] cnt_reg;
    logic pin_reg;
    logic wake_pend_reg;
    logic [3:0] flag_reg;
    logic irq_pulse_reg;
    logic [31:0] rdata_next;
    logic wr_en;
    logic rd_en;
    logic addr_word;
    logic rx_qual;
    logic [3:0] flag_rise;
    logic src_evt;
    logic pin_fall;
    logic wake_armed;
    logic wake_fire;
    logic irq_gate;
    // Bus decode and power-state status
    logic ctrl_wr;
    logic irqen_wr;
    logic settle_wr;
    logic settle_done;
    logic run_now;
    // Source qualification
    logic tx_empty_hit;
    logic tx_idle_hit;
    logic rx_avail_hit;
    logic overrun_hit;
    logic wake_hit;
    logic gie_on;
    logic mfie_on;
    logic pie_on;

    function automatic logic topmost_bit(input logic [8:0] w, input logic nine);
        topmost_bit = nine ? w[8] : w[7];
    endfunction

    // Register address decode
    function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] ofs);
        reg_hit = (a == ofs);
    endfunction

    // Port clock runs only in run state
    function automatic logic is_run(input uiw_pwr_e p);
        is_run = (p == UIW_RUN);
    endfunction

    // Field positions and the settle count must fit their words
    if (UIW_RXEN_BIT >= UIW_CTRL_W || UIW_NINE_BIT >= UIW_CTRL_W) begin : g_bad_ctrl
        $error("control field outside the control word");
    end
    if (UIW_SETTLE_CYC < 1 || UIW_SETTLE_CYC > 65535) begin : g_bad_settle
        $error("settle count does not fit the counter");
    end
    if (UIW_CTRL_W > 32) begin : g_bad_width
        $error("control word wider than the bus");
    end

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;

    // Control registers keep their value across power-down
    assign ctrl_wr = wr_en && reg_hit(paddr, UIW_CTRL_OFS);
    assign irqen_wr = wr_en && reg_hit(paddr, UIW_IRQEN_OFS);
    assign settle_wr = wr_en && reg_hit(paddr, UIW_SETTLE_OFS);

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_reg <= UIW_CTRL_RST;
        end else if (ctrl_wr) begin
            ctrl_reg <= pwdata[UIW_CTRL_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irqen_reg <= UIW_IRQEN_RST;
        end else if (irqen_wr) begin
            irqen_reg <= pwdata[2:0];
        end
    end

    // A count of zero or one both give one settling cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            settle_reg <= UIW_SETTLE_RST;
        end else if (settle_wr) begin
            settle_reg <= pwdata[15:0];
        end
    end
    assign port_control_two = ctrl_reg;

    // Status read-only; writes to it are ignored
    always_comb begin
        rdata_next = 32'h0000_0000;
        unique case (paddr)
            UIW_CTRL_OFS: begin
                rdata_next[UIW_CTRL_W-1:0] = ctrl_reg;
            end
            UIW_STAT_OFS: begin
                rdata_next[0] = ~port_irq_n;
                rdata_next[1] = evt.tx_empty;
                rdata_next[2] = evt.tx_idle;
                rdata_next[3] = evt.overrun;
                rdata_next[4] = evt.rx_avail;
                rdata_next[6:5] = pwr_reg;
                rdata_next[7] = wake_pend_reg;
            end
            UIW_IRQEN_OFS: begin
                rdata_next[2:0] = irqen_reg;
            end
            UIW_SETTLE_OFS: begin
                rdata_next[15:0] = settle_reg;
            end
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    // Read data taken in setup; stands until the next read
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en) begin
            prdata <= rdata_next;
        end
    end

    // Power sequencer: down while clock gated, then settling count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pwr_reg <= UIW_RUN;
        end else begin
            unique case (pwr_reg)
                UIW_RUN: begin
                    if (power_down) begin
                        pwr_reg <= UIW_DOWN;
                    end
                end
                UIW_DOWN: begin
                    if (!power_down) begin
                        pwr_reg <= UIW_SETTLE;
                    end
                end
                UIW_SETTLE: begin
                    if (settle_done) begin
                        pwr_reg <= UIW_RUN;
                    end
                end
                // Unused code falls back to run
                default: pwr_reg <= UIW_RUN;
            endcase
        end
    end

    // Settling counter loads on leaving power-down
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            cnt_reg <= 16'h0000;
        end else if (pwr_reg == UIW_DOWN && !power_down) begin
            cnt_reg <= settle_reg;
        end else if (pwr_reg == UIW_SETTLE && !settle_done) begin
            cnt_reg <= cnt_reg - 16'h0001;
        end else if (pwr_reg == UIW_SETTLE) begin
            cnt_reg <= 16'h0000;
        end
    end

    assign settle_done = (cnt_reg <= 16'h0001);
    assign run_now = is_run(pwr_reg);
    // Port logic outside freezes, not resets, while clock is off
    assign port_clk_run = run_now;
    assign rx_ignore = !run_now;

    // Pin edge watcher; pin input is synchronous
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            pin_reg <= 1'b1;
        end else begin
            pin_reg <= serial_data_pin;
        end
    end
    assign pin_fall = pin_reg && !serial_data_pin;
    assign wake_armed = ctrl_reg[UIW_WAKE_BIT] && ctrl_reg[UIW_PORTEN_BIT]
        && ctrl_reg[UIW_RXEN_BIT] && ctrl_reg[UIW_RIE_BIT];
    assign wake_fire = (pwr_reg == UIW_DOWN) && wake_armed && pin_fall;
    // Wake always reaches the core, interrupt or not
    assign wake_req = wake_fire || wake_pend_reg;

    // Pending wake interrupt, released after settling
    // Set and clear cannot meet: a fire needs power-down
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wake_pend_reg <= 1'b0;
        end else if (wake_fire) begin
            wake_pend_reg <= 1'b1;
        end else if (pwr_reg == UIW_RUN) begin
            wake_pend_reg <= 1'b0;
        end
    end

    // Flag rise detection; one pulse per set event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flag_reg <= 4'h0;
        end else if (pwr_reg == UIW_RUN) begin
            flag_reg <= {evt.overrun, evt.rx_avail, evt.tx_idle, evt.tx_empty};
        end
    end
    assign flag_rise = {evt.overrun, evt.rx_avail, evt.tx_idle, evt.tx_empty} & ~flag_reg;

    assign addr_word = topmost_bit(evt.rx_word, ctrl_reg[UIW_NINE_BIT]);
    // Address qualifier; parity must be off in this mode
    assign rx_qual = ctrl_reg[UIW_ADDEN_BIT] ? addr_word : 1'b1;

    // Transmit sources qualified by their own enables; receive data and overrun share RIE
    assign tx_empty_hit = flag_rise[0] && ctrl_reg[UIW_TEIE_BIT];
    assign tx_idle_hit = flag_rise[1] && ctrl_reg[UIW_TIIE_BIT];
    assign rx_avail_hit = flag_rise[2] && ctrl_reg[UIW_RIE_BIT] && rx_qual;
    assign overrun_hit = flag_rise[3] && ctrl_reg[UIW_RIE_BIT];
    // Pending wake is seen on the first run cycle after settling
    assign wake_hit = wake_pend_reg;

    // Nothing is raised while the port clock is off
    assign src_evt = run_now && (tx_empty_hit || tx_idle_hit || rx_avail_hit
        || overrun_hit || wake_hit);

    // Core gating; the port pulse itself is not masked
    assign gie_on = irqen_reg[UIW_GIE_BIT];
    assign mfie_on = irqen_reg[UIW_MFIE_BIT];
    assign pie_on = irqen_reg[UIW_PIE_BIT];
    assign irq_gate = gie_on && mfie_on && pie_on;

    // Low pulse of one cycle per qualifying event
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_pulse_reg <= 1'b0;
        end else begin
            irq_pulse_reg <= src_evt;
        end
    end
    assign port_irq_n = !irq_pulse_reg;
    assign vector_take = irq_pulse_reg && irq_gate && !stack_full;
endmodule

// file: verification/uiw_irq_wake_props.sv
// Checker for the serial-port interrupt and wake block.
// Sees only the top module's ports; bound at the foot.
module uiw_irq_wake_props
    import uiw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Watched signals
    input wire uiw_evt_s evt,
    input wire logic power_down,
    input wire logic stack_full,
    input wire logic port_clk_run,
    input wire logic rx_ignore,
    input wire logic [UIW_CTRL_W-1:0] port_control_two,
    input wire logic port_irq_n,
    input wire logic vector_take,
    input wire logic wake_req
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!resetn);
    // Topmost data bit follows the word length
    wire top_bit = port_control_two[UIW_NINE_BIT] ? evt.rx_word[8] : evt.rx_word[7];
    a_pulse_single: assert property (!port_irq_n |=> port_irq_n)
        else $error("request longer than one cycle");
    a_take_gated: assert property (vector_take |-> !port_irq_n && !stack_full)
        else $error("vector without request or with full stack");
    a_ignore_mode: assert property (rx_ignore != port_clk_run)
        else $error("receiver ignore disagrees with run state");
    a_down_stops: assert property (power_down && port_clk_run |-> ##[1:3] !port_clk_run)
        else $error("port clock still running in power-down");
    a_addr_block: assert property ($rose(evt.rx_avail) && port_clk_run &&
        port_control_two[UIW_ADDEN_BIT] && !top_bit |=> port_irq_n [*2])
        else $error("data word raised request in address mode");
    a_rx_plain: assert property ($rose(evt.rx_avail) && port_clk_run &&
        port_control_two[UIW_RIE_BIT] && !port_control_two[UIW_ADDEN_BIT]
        |-> ##[1:2] !port_irq_n)
        else $error("receive request missing");
    a_wake_held: assert property (wake_req |-> port_irq_n)
        else $error("wake request before settling ended");
    a_wake_irq: assert property ($fell(wake_req) |-> ##[0:2] !port_irq_n)
        else $error("wake request lost");
    a_wake_down: assert property ($rose(wake_req) |-> rx_ignore && !port_clk_run)
        else $error("wake outside power-down");
    a_hold_ctrl: assert property ($rose(rx_ignore) |-> $stable(port_control_two))
        else $error("control changed on entering power-down");
endmodule

bind uiw_irq_wake uiw_irq_wake_props u_props (.clk, .resetn, .evt, .power_down, .stack_full,
    .port_clk_run, .rx_ignore, .port_control_two, .port_irq_n, .vector_take, .wake_req);

// file: verification/uiw_far_side.sv
// Far-side model: core return stack and remote serial line.
// Assumes the bench commands each start-bit drop.
module uiw_far_side #(
    parameter int STACK_DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Core side
    input wire logic vector_take,
    output logic stack_full,
    output int taken,
    // Line side
    input wire logic drop,
    output logic serial_data_pin
);
    // Vectors push return addresses; never popped, so depth bounds a run
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            taken <= 0;
        end else if (vector_take) begin
            taken <= taken + 1;
        end
    end
    assign stack_full = taken >= STACK_DEPTH;
    // Pull-up holds the idle line high between frames
    assign serial_data_pin = !drop;
endmodule

// file: verification/testbench.sv
// Self-checking bench for the serial-port interrupt and wake block.
// Assumes zero-wait APB and a one-cycle request pulse.
module testbench
    import uiw_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, power_down = 0, drop = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [3:0] flg = 0;
    logic [8:0] word = 0;
    logic pready, pslverr, stack_full, serial_data_pin, port_clk_run, rx_ignore;
    logic port_irq_n, vector_take, wake_req;
    logic [UIW_CTRL_W-1:0] port_control_two;
    int failures = 0, comparisons = 0, pulses = 0, p0, taken;
    wire uiw_evt_s evt = {flg, word};
    always #2 clk = ~clk;
    always @(posedge clk) if (port_irq_n === 1'b0) pulses <= pulses + 1;
    uiw_irq_wake u_uiw_irq_wake (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .evt, .power_down, .stack_full, .serial_data_pin,
        .port_clk_run, .rx_ignore, .port_control_two, .port_irq_n, .vector_take, .wake_req);
    uiw_far_side u_uiw_far_side (.clk, .resetn, .vector_take, .stack_full, .taken, .drop,
        .serial_data_pin);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // Request held until pready is seen; an idle edge follows release
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge clk);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(0, a, 0);
        chk(rd, exp);
    endtask
    // Raise one flag under a control value and count request pulses
    task automatic src(input int i, input logic [8:0] w, input logic [31:0] c, input int n);
        apb(1, UIW_CTRL_OFS, c);
        word <= w;
        p0 = pulses;
        flg[i] <= 1'b1;
        cyc(4);
        chk(pulses - p0, n);
        flg[i] <= 1'b0;
        cyc(2);
    endtask
    task automatic final_report;
        if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        cyc(2);
        resetn <= 1;
        cyc(1);
        rdchk(UIW_CTRL_OFS, 32'(UIW_CTRL_RST));
        rdchk(UIW_IRQEN_OFS, 32'(UIW_IRQEN_RST));
        rdchk(UIW_SETTLE_OFS, 32'(UIW_SETTLE_RST));
        rdchk(8'h10, 32'h0);
        apb(1, UIW_STAT_OFS, 32'hFF);
        rdchk(UIW_STAT_OFS, 32'h0);
        for (int i = 0; i < 4; i++) begin
            src(i, 9'h000, 32'h0, 0);
            src(i, 9'h000, 32'h1 << (i > 1 ? 3 - i : 2), 1);
        end
        src(3, 9'h000, 32'h4, 0);
        src(1, 9'h000, 32'h00C, 0);
        src(1, 9'h080, 32'h00C, 1);
        src(1, 9'h080, 32'h02C, 0);
        src(1, 9'h100, 32'h02C, 1);
        src(1, 9'h000, 32'h004, 1);
        src(0, 9'h000, 32'h00C, 1);
        apb(1, UIW_IRQEN_OFS, 32'h7);
        src(0, 9'h000, 32'h004, 1);
        chk(taken, 1);
        apb(1, UIW_SETTLE_OFS, 32'h8);
        apb(1, UIW_CTRL_OFS, 32'h194);
        power_down <= 1;
        cyc(4);
        drop <= 1;
        cyc(3);
        chk(wake_req, 1);
        chk(rx_ignore, 1);
        chk(port_clk_run, 0);
        p0 = pulses;
        power_down <= 0;
        drop <= 0;
        cyc(7);
        chk(pulses - p0, 0);
        cyc(8);
        chk(pulses - p0, 1);
        chk(taken, 2);
        rdchk(UIW_CTRL_OFS, 32'h194);
        chk(port_control_two, 32'h194);
        chk(port_clk_run, 1);
        final_report;
    end
    // Whole sequence needs well under 2000 cycles
    initial begin
        #40000;
        failures++;
        final_report;
    end
endmodule
